// ===== common/vcrb_regs.vh
`ifndef VCRB_REGS_VH
`define VCRB_REGS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define VCRB_OFS_VCODE 8'h00
`define VCRB_OFS_CTRL 8'h01

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define VCRB_VCODE_PARITY_BIT 7
`define VCRB_VCODE_RESET 7'h32
`define VCRB_CTRL_INTERNAL_BIT 7
`define VCRB_CTRL_PROT_OFF_BIT 4
`define VCRB_CTRL_PWM_BIT 3
`define VCRB_CTRL_LATCH_BIT 0
`define VCRB_CTRL_MASK 8'h99
`define VCRB_CTRL_RESET 8'h09

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define VCRB_CLK_PERIOD_NS 5
`define VCRB_SPIKE_NS 32
`define VCRB_SPIKE_CYC ((`VCRB_SPIKE_NS + `VCRB_CLK_PERIOD_NS - 1) / `VCRB_CLK_PERIOD_NS)

`endif

// ===== src/vcrb_ctrl_bank.v
// Contract
// R1 - Master sends parity as XNOR of code.
// R2 - Bad parity: no acknowledge, keep contents.
// R3 - Master repeats a transfer left unacknowledged.
// R4 - Voltage read returns stored parity and code.
// R5 - Voltage code resets to 0110010.
// R6 - Control bit 7 selects internal code control.
// R7 - Control bit 4 suppresses protection on change.
// R8 - Control bit 3 picks PWM, reset one.
// R9 - Control bit 0 picks latch-off, reset one.
// R10 - Filter spikes up to 32 ns.
// R11 - Voltage at address 00, control at 01.
// R12 - Address mismatch: no acknowledge, wait start.
// R13 - Read sends stored byte, then resumes.
// R14 - Undefined control bits read zero.
`timescale 1ns/1ps
`include "vcrb_regs.vh"

// ----------------------------------------------------------------------
// Spike filter
// ----------------------------------------------------------------------
module vcrb_glitch_filter #(
  parameter SPIKE_CYC = 7
) (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire raw_in,
  output reg filt_out
);
  // Five bits cover filter lengths up to 31 clocks.
  reg [4:0] cnt_reg;

  // A new level is accepted only after it outlasts the longest spike.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 5'h00;
      filt_out <= 1'b1;
    end else if (clk_en) begin
      if (raw_in == filt_out) begin
        cnt_reg <= 5'h00;
      end else if (cnt_reg >= SPIKE_CYC[4:0]) begin
        cnt_reg <= 5'h00;
        filt_out <= raw_in;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
    end
  end
endmodule

// ----------------------------------------------------------------------
// Serial slave and register bank
// ----------------------------------------------------------------------
module vcrb_ctrl_bank #(
  parameter [6:0] BASE_ADDR = 7'h50
) (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire addr_sel,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  output wire [6:0] output_voltage_code,
  output wire code_parity,
  output wire internal_mode,
  output wire prot_off_on_change,
  output wire light_load_pwm_select,
  output wire latch_off_mode
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ACK_ADDR = 4'h2;
  localparam [3:0] ST_PTR = 4'h3;
  localparam [3:0] ST_ACK_PTR = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_ACK_DATA = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;
  localparam [3:0] ST_IGNORE = 4'h9;

  wire scl_f;
  wire sda_f;
  reg scl_d_reg;
  reg sda_d_reg;
  reg [3:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg [7:0] ptr_reg;
  reg rw_reg;
  reg master_ack_reg;
  reg [7:0] vcode_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] read_byte;
  wire start_det;
  wire stop_det;
  wire scl_rise;
  wire scl_fall;
  wire addr_match;
  wire parity_ok;

  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  // Both lines pass through identical filters, so their relative timing is
  // kept and a start or stop is never mistaken for a data edge.
  // R10 spike filters
  vcrb_glitch_filter #(
    .SPIKE_CYC(`VCRB_SPIKE_CYC)
  ) u_scl_filt (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .raw_in(scl_in),
    .filt_out(scl_f)
  );

  vcrb_glitch_filter #(
    .SPIKE_CYC(`VCRB_SPIKE_CYC)
  ) u_sda_filt (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .raw_in(sda_in),
    .filt_out(sda_f)
  );

  // ----------------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------------
  // Events come from the filtered levels one clock late; the extra clock is
  // far below a bus bit time and keeps every event a plain register compare.
  assign start_det = scl_f && scl_d_reg && sda_d_reg && !sda_f;
  assign stop_det = scl_f && scl_d_reg && !sda_d_reg && sda_f;
  assign scl_rise = scl_f && !scl_d_reg;
  assign scl_fall = !scl_f && scl_d_reg;
  assign addr_match = (shift_reg[7:1] == {BASE_ADDR[6:1], addr_sel});
  // R2 parity check
  assign parity_ok = (shift_reg[7] == ~^shift_reg[6:0]);

  // ----------------------------------------------------------------------
  // Register outputs
  // ----------------------------------------------------------------------
  assign output_voltage_code = vcode_reg[6:0];
  assign code_parity = vcode_reg[`VCRB_VCODE_PARITY_BIT];
  // R6 control source
  assign internal_mode = ctrl_reg[`VCRB_CTRL_INTERNAL_BIT];
  // R7 protection suppression
  assign prot_off_on_change = ctrl_reg[`VCRB_CTRL_PROT_OFF_BIT];
  // R8 light-load mode
  assign light_load_pwm_select = ctrl_reg[`VCRB_CTRL_PWM_BIT];
  // R9 fault response
  assign latch_off_mode = ctrl_reg[`VCRB_CTRL_LATCH_BIT];

  // ----------------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------------
  // R11 read decode
  always @* begin
    case (ptr_reg)
      // R4 parity readback
      `VCRB_OFS_VCODE: read_byte = vcode_reg;
      // R14 undefined bits zero
      `VCRB_OFS_CTRL: read_byte = ctrl_reg & `VCRB_CTRL_MASK;
      default: read_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Serial slave state machine
  // ----------------------------------------------------------------------
  // The pointer survives a stop, so a later plain read returns the register
  // that was addressed last.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      // R5 reset code with matching parity
      vcode_reg <= {~^`VCRB_VCODE_RESET, `VCRB_VCODE_RESET};
      ctrl_reg <= `VCRB_CTRL_RESET;
    end else if (clk_en) begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      sda_out <= 1'b0;
      if (start_det) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        // R13 back to normal after stop
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state_reg == ST_RACK) begin
          master_ack_reg <= !sda_f;
        end else begin
          shift_reg <= {shift_reg[6:0], sda_f};
        end
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bit_cnt_reg == 4'h8) begin
              // R12 ignore foreign address
              if (addr_match) begin
                sda_oe <= 1'b1;
                rw_reg <= shift_reg[0];
                state_reg <= ST_ACK_ADDR;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_ACK_ADDR: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              // R13 send stored byte
              tx_reg <= {read_byte[6:0], 1'b0};
              sda_oe <= ~read_byte[7];
              state_reg <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state_reg <= ST_PTR;
            end
          end
          ST_PTR: begin
            if (bit_cnt_reg == 4'h8) begin
              ptr_reg <= shift_reg;
              sda_oe <= 1'b1;
              state_reg <= ST_ACK_PTR;
            end
          end
          ST_ACK_PTR: begin
            sda_oe <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WDATA;
          end
          ST_WDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              state_reg <= ST_ACK_DATA;
              // A refused byte leaves sda_oe low, which the master reads as no acknowledge.
              if (ptr_reg == `VCRB_OFS_VCODE) begin
                // R2 commit only with good parity
                if (parity_ok) begin
                  vcode_reg <= shift_reg;
                  sda_oe <= 1'b1;
                end
              end else if (ptr_reg == `VCRB_OFS_CTRL) begin
                // R14 undefined bits not stored
                ctrl_reg <= shift_reg & `VCRB_CTRL_MASK;
                sda_oe <= 1'b1;
              end
            end
          end
          ST_ACK_DATA: begin
            sda_oe <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt_reg == 4'h8) begin
              sda_oe <= 1'b0;
              state_reg <= ST_RACK;
            end else begin
              sda_oe <= ~tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            // A master acknowledge asks for the same byte again; the pointer stays.
            bit_cnt_reg <= 4'h0;
            if (master_ack_reg) begin
              tx_reg <= {read_byte[6:0], 1'b0};
              sda_oe <= ~read_byte[7];
              state_reg <= ST_RDATA;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_IGNORE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            sda_oe <= 1'b0;
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== testbench/vcrb_checker.sv
`timescale 1ns/1ps
module vcrb_checker (
  input wire clk,
  input wire reset,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [6:0] output_voltage_code,
  input wire code_parity,
  input wire internal_mode,
  input wire prot_off_on_change,
  input wire light_load_pwm_select,
  input wire latch_off_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence released;
    $fell(reset);
  endsequence
  AST_PAR: assert property (code_parity == ~^output_voltage_code)
    else $error("stored parity");
  AST_VRST: assert property (released |-> output_voltage_code == 7'h32)
    else $error("code reset");
  AST_CRST: assert property (released |-> internal_mode == 1'b0 &&
    prot_off_on_change == 1'b0 && light_load_pwm_select && latch_off_mode)
    else $error("control reset");
  AST_VUPD: assert property ($changed(output_voltage_code) |-> sda_oe)
    else $error("code change without ack");
  AST_CUPD: assert property ($changed({internal_mode, latch_off_mode}) |-> sda_oe)
    else $error("control change without ack");
  AST_OD: assert property (sda_out == 1'b0)
    else $error("data driven high");
  AST_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved with clock high");
  AST_FILT: assert property ($changed(sda_oe) |-> $past(!scl_in, 7))
    else $error("clock fall not filtered");
endmodule

bind vcrb_ctrl_bank vcrb_checker i_vcrb_checker (.clk(clk), .reset(reset),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .output_voltage_code(output_voltage_code), .code_parity(code_parity),
  .internal_mode(internal_mode), .prot_off_on_change(prot_off_on_change),
  .light_load_pwm_select(light_load_pwm_select), .latch_off_mode(latch_off_mode));

// ===== testbench/vcrb_i2c_master.sv
`timescale 1ns/1ps
module vcrb_i2c_master (
  input wire clk,
  input wire sda,
  output logic scl = 1'b1,
  output logic sda_m = 1'b1
);
  // Inverse pulse width on SDA in each high phase; zero for a clean bus.
  int glitch = 0;
  // Level put on the acknowledge slot; low acknowledges a read byte.
  logic ack_lvl = 1'b1;
  task automatic q(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    q(16);
    scl <= 1'b1;
    q(8);
    if (glitch > 0) begin
      sda_m <= ~b;
      q(glitch);
      sda_m <= b;
    end
    q(8);
    r = sda;
    scl <= 1'b0;
    q(16);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    q(16);
    scl <= 1'b1;
    q(16);
    sda_m <= 1'b0;
    q(16);
    scl <= 1'b0;
    q(16);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    q(16);
    scl <= 1'b1;
    q(16);
    sda_m <= 1'b1;
    q(16);
  endtask
  // master nacks reads unless ack_lvl is low
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ack_lvl, a);
    ack = ~a;
  endtask
endmodule

// ===== testbench/vid_control_register_bank_bench.sv
`timescale 1ns/1ps
module vid_control_register_bank_bench;
  localparam logic [6:0] BASE = 7'h50;
  localparam logic [6:0] DEV = {BASE[6:1], 1'b1};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic addr_sel = 1'b1;
  wire scl, sda_m, sda_out, sda_oe, par;
  wire [6:0] code;
  wire [3:0] ctl;
  // Pull-up on the open-drain line: a released SDA reads high.
  wire sda = sda_m & ~sda_oe;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [2:0] k;
  logic [7:0] d;
  logic [7:0] d2;
  logic [7:0] tbl [4] = '{8'hFF, 8'h00, 8'h99, 8'h66};
  always #2.5 clk = ~clk;
  vcrb_ctrl_bank #(.BASE_ADDR(BASE)) i_vcrb_ctrl_bank (.clk(clk), .reset(reset),
    .clk_en(1'b1), .addr_sel(addr_sel), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .output_voltage_code(code), .code_parity(par),
    .internal_mode(ctl[3]), .prot_off_on_change(ctl[2]),
    .light_load_pwm_select(ctl[1]), .latch_off_mode(ctl[0]));
  vcrb_i2c_master i_vcrb_i2c_master (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] vb(input logic [6:0] c);
    return {~^c, c};
  endfunction
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    i_vcrb_i2c_master.start();
    i_vcrb_i2c_master.xfer({a, 1'b0}, r, k[2]);
    i_vcrb_i2c_master.xfer(p, r, k[1]);
    i_vcrb_i2c_master.xfer(v, r, k[0]);
    i_vcrb_i2c_master.stop();
  endtask
  task automatic rd(input logic [7:0] p);
    logic [7:0] r;
    logic a;
    i_vcrb_i2c_master.start();
    i_vcrb_i2c_master.xfer({DEV, 1'b0}, r, a);
    i_vcrb_i2c_master.xfer(p, r, a);
    i_vcrb_i2c_master.start();
    i_vcrb_i2c_master.xfer({DEV, 1'b1}, r, a);
    i_vcrb_i2c_master.xfer(8'hFF, d, a);
    i_vcrb_i2c_master.stop();
  endtask
  // Read at the kept pointer with a master ack, so the byte comes twice.
  task automatic rd_again();
    logic [7:0] r;
    logic a;
    i_vcrb_i2c_master.start();
    i_vcrb_i2c_master.xfer({DEV, 1'b1}, r, a);
    i_vcrb_i2c_master.ack_lvl = 1'b0;
    i_vcrb_i2c_master.xfer(8'hFF, d2, a);
    i_vcrb_i2c_master.ack_lvl = 1'b1;
    i_vcrb_i2c_master.xfer(8'hFF, d, a);
    i_vcrb_i2c_master.stop();
  endtask
  task automatic dflt();
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (12) @(posedge clk);
    check({par, code}, 8'h32);
    check({4'h0, ctl}, 8'h03);
    rd(8'h00);
    check(d, 8'h32);
    rd(8'h01);
    check(d, 8'h09);
  endtask
  // Cuts a hang short; the full run needs about 35000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    dflt();
    wr(DEV, 8'h00, vb(7'h55));
    check({5'h00, k}, 8'h07);
    rd(8'h00);
    check(d, vb(7'h55));
    rd_again();
    check(d2, vb(7'h55));
    check(d, vb(7'h55));
    wr(DEV, 8'h00, vb(7'h0F) ^ 8'h80);
    check({5'h00, k}, 8'h06);
    check({par, code}, vb(7'h55));
    wr(DEV, 8'h00, vb(7'h0F));
    check({par, code}, vb(7'h0F));
    foreach (tbl[i]) begin
      wr(DEV, 8'h01, tbl[i]);
      rd(8'h01);
      check(d, tbl[i] & 8'h99);
      check({4'h0, ctl}, {4'h0, tbl[i][7], tbl[i][4], tbl[i][3], tbl[i][0]});
    end
    wr(DEV, 8'h02, 8'h55);
    check({5'h00, k}, 8'h06);
    wr(BASE, 8'h01, 8'h81);
    check({1'b0, k, ctl}, 8'h00);
    addr_sel <= 1'b0;
    wr(BASE, 8'h01, 8'h81);
    addr_sel <= 1'b1;
    check({5'h00, k}, 8'h07);
    i_vcrb_i2c_master.glitch = 7;
    wr(DEV, 8'h01, 8'h18);
    i_vcrb_i2c_master.glitch = 0;
    check({1'b0, k, ctl}, 8'h76);
    reset <= 1'b1;
    dflt();
    conclude();
  end
endmodule
